// File: sim/ipc_field.sv
`timescale 1ns/100ps
`default_nettype none
// Field sensors: resting levels plus timed pulses
module ipc_field #(
  parameter int N = 14
) (
  input  wire logic         i_clk,
  output logic [N-1:0]      o_din
);
  logic [N-1:0] base;  // Resting level per input
  initial begin
    base = '0;
    o_din = '0;
  end
  // Set resting levels just after an edge
  task automatic rest(input logic [N-1:0] v);
    @(posedge i_clk);
    base = v;
    o_din <= v;
  endtask
  // Pulse away from rest for len cycles
  task automatic pulse(input int b, input int len);
    @(posedge i_clk);
    o_din[b] <= ~base[b];
    repeat (len) @(posedge i_clk);
    o_din[b] <= base[b];
  endtask
endmodule
`default_nettype wire

// File: sim/ipc_properties.sv
`timescale 1ns/100ps
`default_nettype none
// Port-level checks, single clock domain
module ipc_props #(
  parameter int N_IN  = 14,
  parameter int N_OUT = 10
) (
  input wire logic               i_sys_clk,
  input wire logic               i_sys_rst,
  input wire logic               i_ce,
  input wire logic               i_psel,
  input wire logic               i_penable,
  input wire logic               i_pwrite,
  input wire logic [7:0]         i_paddr,
  input wire ipc_pkg::ipc_word_t i_pwdata,
  input wire ipc_pkg::ipc_word_t o_prdata,
  input wire logic               o_pready,
  input wire logic               o_pslverr,
  input wire logic [N_IN-1:0]    i_din,
  input wire logic               i_run,
  input wire logic               i_scan_start,
  input wire logic [N_OUT-1:0]   o_dout,
  input wire ipc_pkg::ipc_mode_e o_mode
);
  import ipc_pkg::*;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  // Ready only in an enabled access phase
  AST_READY: assert property (
    o_pready == (i_psel && i_penable && i_ce)) else $error("ready mismatch");
  AST_ERR_READY: assert property (
    o_pslverr |-> o_pready) else $error("error without ready");
  // Mapped words never answer with an error
  AST_ERR_MAPPED: assert property (
    o_pready && i_paddr <= 8'h1C && i_paddr[1:0] == 2'b00 |-> !o_pslverr)
    else $error("error on mapped word");
  AST_STOP_ENTRY: assert property (
    o_mode == IPC_RUN && !i_run && i_ce |=> o_mode == IPC_STOP) else $error("no stop");
  AST_STOP_KEEP: assert property (
    o_mode == IPC_STOP && !i_run |=> o_mode == IPC_STOP) else $error("left stop");
  AST_RUN_ENTRY: assert property (
    o_mode == IPC_STOP && i_run && i_ce |=> o_mode == IPC_RUN) else $error("no run");
  // Outputs stand still for the whole stop period
  AST_STOP_HOLD: assert property (
    o_mode == IPC_STOP && $past(o_mode) == IPC_STOP |-> $stable(o_dout))
    else $error("outputs moved in stop");
  // Clock enable low freezes outputs and mode
  AST_CE_FREEZE: assert property (
    !i_ce |=> $stable(o_dout) && $stable(o_mode)) else $error("moved without enable");
endmodule
`default_nettype wire

// File: sim/test_input_pulse_catch_and_stop_outputs.sv
`timescale 1ns/100ps
`default_nettype none
module test_input_pulse_catch_and_stop_outputs;
  import ipc_pkg::*;
  localparam int NI = 14;
  localparam int NO = 10;
  localparam int FB = 4;  // Filter base step in cycles, kept short for simulation
  logic clk = 0, rst = 1, ce = 1, psel = 0, pen = 0, pwr = 0, run = 0, scan = 0;
  logic [7:0] addr = '0;
  ipc_word_t wdata = '0, rdata, exp, prdata, img;
  logic pready, pslverr, err;
  logic [NI-1:0] din, m_base = '0, m_caught = '0, m_latch = '0, m_en = 14'h0003;
  logic [NO-1:0] dout, t1;
  ipc_mode_e mode;
  int errors = 0, n_checks = 0;
  always #5 clk = ~clk;
  ipc_top #(.N_IN(NI), .N_OUT(NO), .FILT_BASE_CYC(FB), .CW(21)) DUT (.i_sys_clk(clk),
    .i_sys_rst(rst), .i_ce(ce), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(addr), .i_pwdata(wdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_din(din), .i_run(run), .i_scan_start(scan),
    .o_dout(dout), .o_mode(mode));
  ipc_field #(.N(NI)) u_field (.i_clk(clk), .o_din(din));
  task automatic test_done();
    if (errors == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input ipc_word_t got, input ipc_word_t want);
    n_checks++;
    if (got !== want) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  // One APB transfer, held until ready
  task automatic apb(input logic w, input logic [7:0] a, input ipc_word_t d);
    @(posedge clk);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    pen <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdata = prdata;
    err = pslverr;
    psel <= 0;
    pen <= 0;
  endtask
  // Pulse through the field, model the catch latch
  task automatic pulse(input int b, input int len);
    u_field.pulse(b, len);
    // Filter code 0 passes a level that stands FB sampled edges
    if (m_en[b] && len >= FB && !m_caught[b]) begin
      m_caught[b] = 1;
      m_latch[b] = ~m_base[b];
    end
    repeat (12) @(posedge clk);
  endtask
  // Scan start, then compare the input image
  task automatic scan_chk();
    @(posedge clk);
    scan <= 1;
    @(posedge clk);
    scan <= 0;
    exp = 32'((m_base & ~m_caught) | (m_latch & m_caught));
    m_caught = '0;
    apb(0, 8'h14, 0);
    chk(rdata, exp);
  endtask
  // Run then stop, compare outputs held in stop
  task automatic run_stop(input ipc_word_t want);
    run <= 1;
    repeat (4) @(posedge clk);
    run <= 0;
    repeat (4) @(posedge clk);
    chk(32'(dout), want);
    chk(32'(mode), 32'(IPC_STOP));
  endtask
  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    test_done();
  end
  initial begin
    void'($urandom(56252));
    repeat (3) @(posedge clk);
    rst <= 0;
    apb(0, 8'h04, 0);
    chk(rdata, 0);
    apb(0, 8'h40, 0);
    chk(32'(err), 1);
    t1 = NO'($urandom);
    apb(1, 8'h00, 32'h0000_0003);
    apb(1, 8'h08, 32'h0000_0000);
    apb(1, 8'h04, 32'(t1));
    apb(1, 8'h0C, 32'h0000_0002);
    apb(1, 8'h04, 32'(~t1));
    apb(1, 8'h10, 32'h0000_03FF & $urandom);
    run_stop(32'(t1));
    // Freeze: outputs keep the running image
    apb(1, 8'h0C, 32'h0000_0003);
    img = 32'h0000_03FF & $urandom;
    apb(1, 8'h10, img);
    ce <= 0;
    repeat (3) @(posedge clk);
    ce <= 1;
    run_stop(img);
    // Status: stopped, freeze active
    apb(0, 8'h18, 0);
    chk(rdata, 32'h0000_0003);
    // Catch: high, low, disabled and filtered-out pulses
    m_base = 14'h0002;
    u_field.rest(m_base);
    repeat (20) @(posedge clk);
    scan_chk();
    pulse(0, 12);
    pulse(1, 12);
    pulse(0, 12);
    pulse(2, 12);
    pulse(3, 1);
    // Pending catch flags, before the update takes them
    apb(0, 8'h1C, 0);
    chk(rdata, 32'(m_caught));
    scan_chk();
    scan_chk();
    // Defaults clear table and freeze
    apb(1, 8'h0C, 32'h0000_0004);
    apb(0, 8'h04, 0);
    chk(rdata, 0);
    run_stop(0);
    apb(0, 8'h18, 0);
    chk(rdata, 32'h0000_0001);
    // Reset in mid-run: outputs off, mode back to stop
    img = 32'(NO'($urandom)) | 32'h0000_0001;
    apb(1, 8'h10, img);
    run <= 1;
    repeat (4) @(posedge clk);
    chk(32'(dout), img);
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    run <= 0;
    chk(32'(dout), 0);
    chk(32'(mode), 32'(IPC_STOP));
    repeat (2) @(posedge clk);
    test_done();
  end
endmodule
bind ipc_top ipc_props #(.N_IN(N_IN), .N_OUT(N_OUT)) u_props (.i_sys_clk(i_sys_clk),
  .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .i_din(i_din), .i_run(i_run),
  .i_scan_start(i_scan_start), .o_dout(o_dout), .o_mode(o_mode));
`default_nettype wire

// File: verilog/ipc_defines.svh
`ifndef IPC_DEFINES_SVH
`define IPC_DEFINES_SVH

// Register byte offsets
`define IPC_OFS_CATCH     8'h00
`define IPC_OFS_TABLE     8'h04
`define IPC_OFS_FILT      8'h08
`define IPC_OFS_CTRL      8'h0C
`define IPC_OFS_OIMG      8'h10
`define IPC_OFS_IIMG      8'h14
`define IPC_OFS_STAT      8'h18
`define IPC_OFS_CAUGHT    8'h1C

// Control register fields
`define IPC_CTRL_FREEZE   0
`define IPC_CTRL_LOAD     1
`define IPC_CTRL_DEFAULT  2

// Status register fields
`define IPC_STAT_STOP     0
`define IPC_STAT_FRZ      1

// Default sizes
`define IPC_N_IN_DEF      14
`define IPC_N_OUT_DEF     10
`define IPC_GRP_SIZE      4
`define IPC_CODE_W        3

// Reset values and filter code limit
`define IPC_CATCH_RST     32'h0000_0000
`define IPC_TABLE_RST     32'h0000_0000
`define IPC_FILT_CODE_RST 3'h5
`define IPC_FILT_CODE_MAX 3'h6

// Filter timing: base step, doubled per code up to code 6
`define IPC_CLK_PERIOD_NS 10
`define IPC_FILT_BASE_NS  200000
`define IPC_FILT_BASE_CYC (`IPC_FILT_BASE_NS / `IPC_CLK_PERIOD_NS)
`define IPC_FILT_CW       21

`endif

// File: verilog/ipc_pkg.sv
`default_nettype none
package ipc_pkg;

  // Controller operating mode
  typedef enum logic {
    IPC_RUN,
    IPC_STOP
  } ipc_mode_e;

  // Bus data word
  typedef logic [31:0] ipc_word_t;

endpackage
`default_nettype wire

// File: verilog/ipc_top.sv
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "ipc_defines.svh"

module ipc_top #(
  parameter int N_IN          = `IPC_N_IN_DEF,
  parameter int N_OUT         = `IPC_N_OUT_DEF,
  parameter int FILT_BASE_CYC = `IPC_FILT_BASE_CYC,
  parameter int CW            = `IPC_FILT_CW
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_sys_rst,
  input  wire logic              i_ce,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [7:0]        i_paddr,
  input  wire ipc_pkg::ipc_word_t i_pwdata,
  output var  ipc_pkg::ipc_word_t o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  input  wire logic [N_IN-1:0]   i_din,
  input  wire logic              i_run,
  input  wire logic              i_scan_start,
  output logic [N_OUT-1:0]       o_dout,
  output var  ipc_pkg::ipc_mode_e o_mode
);
  import ipc_pkg::*;

  // Filter groups and width of the packed code field
  localparam int NG = (N_IN + `IPC_GRP_SIZE - 1) / `IPC_GRP_SIZE;
  localparam int FW = NG * `IPC_CODE_W;

  // Shadow configuration, written by software
  logic [N_IN-1:0]  catch_sh_reg, catch_sh_next;
  logic [N_OUT-1:0] table_sh_reg, table_sh_next;
  logic [FW-1:0]    filt_sh_reg,  filt_sh_next;
  logic             frz_sh_reg,   frz_sh_next;
  // Active configuration, used by the logic
  logic [N_IN-1:0]  catch_act_reg, catch_act_next;
  logic [N_OUT-1:0] table_act_reg, table_act_next;
  logic [FW-1:0]    filt_act_reg,  filt_act_next;
  logic             frz_act_reg,   frz_act_next;
  // Program output image
  logic [N_OUT-1:0] oimg_reg, oimg_next;
  // Bus answer registers
  ipc_word_t        prdata_reg, prdata_next;
  logic             slverr_reg, slverr_next;
  // Mode, outputs and input image
  ipc_mode_e        mode_reg, mode_next;
  logic [N_OUT-1:0] dout_reg, dout_next;
  logic [N_IN-1:0]  iimg_reg, iimg_next;
  // Per input views out of the generate loop
  logic [N_IN-1:0]  smp_v;
  logic [N_IN-1:0]  cau_v;

  // Bus phase decode and default filter codes
  logic             setup_ph;
  logic             wr_acc;
  logic [FW-1:0]    filt_rst;

  assign setup_ph = i_psel & ~i_penable;
  assign wr_acc   = i_psel & i_penable & i_pwrite & i_ce;
  assign filt_rst = {NG{`IPC_FILT_CODE_RST}};

  // Zero wait state slave; held off while the clock enable i_ce is low
  assign o_pready  = i_psel & i_penable & i_ce;
  assign o_pslverr = o_pready & slverr_reg;
  assign o_prdata  = prdata_reg;
  assign o_dout    = dout_reg;
  assign o_mode    = mode_reg;

  // Configuration next state
  always_comb begin
    catch_sh_next  = catch_sh_reg;
    table_sh_next  = table_sh_reg;
    filt_sh_next   = filt_sh_reg;
    frz_sh_next    = frz_sh_reg;
    catch_act_next = catch_act_reg;
    table_act_next = table_act_reg;
    filt_act_next  = filt_act_reg;
    frz_act_next   = frz_act_reg;
    oimg_next      = oimg_reg;
    if (wr_acc) begin
      case (i_paddr)
        `IPC_OFS_CATCH: begin
          catch_sh_next = i_pwdata[N_IN-1:0];
        end
        `IPC_OFS_TABLE: begin
          table_sh_next = i_pwdata[N_OUT-1:0];
        end
        `IPC_OFS_FILT: begin
          filt_sh_next = i_pwdata[FW-1:0];
        end
        `IPC_OFS_CTRL: begin
          frz_sh_next = i_pwdata[`IPC_CTRL_FREEZE];
          if (i_pwdata[`IPC_CTRL_LOAD]) begin
            catch_act_next = catch_sh_reg;
            table_act_next = table_sh_reg;
            filt_act_next  = filt_sh_reg;
            frz_act_next   = i_pwdata[`IPC_CTRL_FREEZE];
          end
          if (i_pwdata[`IPC_CTRL_DEFAULT]) begin
            catch_sh_next  = N_IN'(`IPC_CATCH_RST);
            table_sh_next  = N_OUT'(`IPC_TABLE_RST);
            filt_sh_next   = filt_rst;
            frz_sh_next    = 1'b0;
            catch_act_next = N_IN'(`IPC_CATCH_RST);
            table_act_next = N_OUT'(`IPC_TABLE_RST);
            filt_act_next  = filt_rst;
            frz_act_next   = 1'b0;
          end
        end
        `IPC_OFS_OIMG: begin
          oimg_next = i_pwdata[N_OUT-1:0];
        end
        // Read-only and unmapped: writes ignored
        default: begin
          oimg_next = oimg_reg;
        end
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      catch_sh_reg  <= N_IN'(`IPC_CATCH_RST);
      table_sh_reg  <= N_OUT'(`IPC_TABLE_RST);
      filt_sh_reg   <= {NG{`IPC_FILT_CODE_RST}};
      frz_sh_reg    <= 1'b0;
      catch_act_reg <= N_IN'(`IPC_CATCH_RST);
      table_act_reg <= N_OUT'(`IPC_TABLE_RST);
      filt_act_reg  <= {NG{`IPC_FILT_CODE_RST}};
      frz_act_reg   <= 1'b0;
      oimg_reg      <= N_OUT'(`IPC_TABLE_RST);
    end else if (i_ce) begin
      catch_sh_reg  <= catch_sh_next;
      table_sh_reg  <= table_sh_next;
      filt_sh_reg   <= filt_sh_next;
      frz_sh_reg    <= frz_sh_next;
      catch_act_reg <= catch_act_next;
      table_act_reg <= table_act_next;
      filt_act_reg  <= filt_act_next;
      frz_act_reg   <= frz_act_next;
      oimg_reg      <= oimg_next;
    end
  end

  // Read data prepared in the setup cycle
  always_comb begin
    prdata_next = prdata_reg;
    slverr_next = slverr_reg;
    if (setup_ph) begin
      slverr_next = 1'b0;
      case (i_paddr)
        `IPC_OFS_CATCH: begin
          prdata_next = 32'(catch_sh_reg);
        end
        `IPC_OFS_TABLE: begin
          prdata_next = 32'(table_sh_reg);
        end
        `IPC_OFS_FILT: begin
          prdata_next = 32'(filt_sh_reg);
        end
        `IPC_OFS_CTRL: begin
          // Load and default bits are pulses, read zero
          prdata_next = 32'(frz_sh_reg);
        end
        `IPC_OFS_OIMG: begin
          prdata_next = 32'(oimg_reg);
        end
        `IPC_OFS_IIMG: begin
          prdata_next = 32'(iimg_reg);
        end
        `IPC_OFS_STAT: begin
          prdata_next = 32'h0000_0000;
          prdata_next[`IPC_STAT_STOP] = (mode_reg == IPC_STOP);
          prdata_next[`IPC_STAT_FRZ]  = frz_act_reg;
        end
        `IPC_OFS_CAUGHT: begin
          prdata_next = 32'(cau_v);
        end
        // Unmapped address answers with an error
        default: begin
          prdata_next = 32'h0000_0000;
          slverr_next = 1'b1;
        end
      endcase
    end
  end

  // Bus answer registers
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      prdata_reg <= 32'h0000_0000;
      slverr_reg <= 1'b0;
    end else if (i_ce) begin
      prdata_reg <= prdata_next;
      slverr_reg <= slverr_next;
    end
  end

  // Per input filter and catch latch
  for (genvar gi = 0; gi < N_IN; gi++) begin : g_in
    logic [CW-1:0]           cnt_reg, cnt_next;
    logic                    filt_reg, filt_next;
    logic                    lat_reg, lat_next;
    logic                    cau_reg, cau_next;
    logic [`IPC_CODE_W-1:0]  code;
    logic [CW-1:0]           thr;

    // Code field of this input's group of four
    assign code = filt_act_reg[(gi / `IPC_GRP_SIZE) * `IPC_CODE_W +: `IPC_CODE_W];
    assign thr  = (code > `IPC_FILT_CODE_MAX)
                ? (CW'(FILT_BASE_CYC) << `IPC_FILT_CODE_MAX)
                : (CW'(FILT_BASE_CYC) << code);
    // Caught value wins, else live filtered level
    assign smp_v[gi] = (catch_act_reg[gi] & cau_reg) ? lat_reg : filt_reg;
    assign cau_v[gi] = cau_reg;

    // Filter and latch next state
    always_comb begin
      cnt_next  = cnt_reg;
      filt_next = filt_reg;
      lat_next  = lat_reg;
      cau_next  = cau_reg;
      // Level must differ for the whole delay to pass
      if (i_din[gi] == filt_reg) begin
        cnt_next = '0;
      end else if (cnt_reg >= thr - CW'(1)) begin
        cnt_next  = '0;
        filt_next = i_din[gi];
      end else begin
        cnt_next = cnt_reg + CW'(1);
      end
      if (i_scan_start) begin
        lat_next = filt_reg;
        cau_next = 1'b0;
      end else if (!cau_reg) begin
        lat_next = filt_reg;
        cau_next = catch_act_reg[gi] & (filt_reg != lat_reg);
      end else begin
        lat_next = lat_reg;
      end
    end

    // Filter and latch registers
    always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
        cnt_reg  <= '0;
        filt_reg <= 1'b0;
        lat_reg  <= 1'b0;
        cau_reg  <= 1'b0;
      end else if (i_ce) begin
        cnt_reg  <= cnt_next;
        filt_reg <= filt_next;
        lat_reg  <= lat_next;
        cau_reg  <= cau_next;
      end
    end
  end

  // Mode, outputs and input image next state
  always_comb begin
    mode_next = mode_reg;
    dout_next = dout_reg;
    iimg_next = iimg_reg;
    if (i_scan_start) begin
      iimg_next = smp_v;
    end
    // digital points only, no analog image
    case (mode_reg)
      IPC_RUN: begin
        if (!i_run) begin
          mode_next = IPC_STOP;
          if (frz_act_reg) begin
            dout_next = dout_reg;
          end else begin
            dout_next = table_act_reg;
          end
        end else begin
          dout_next = oimg_reg;
        end
      end
      IPC_STOP: begin
        // stop values on digital bits only
        if (i_run) begin
          mode_next = IPC_RUN;
        end
      end
      default: begin
        mode_next = IPC_STOP;
      end
    endcase
  end

  // Mode, outputs and input image registers
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      mode_reg <= IPC_STOP;
      dout_reg <= N_OUT'(`IPC_TABLE_RST);
      iimg_reg <= N_IN'(`IPC_CATCH_RST);
    end else if (i_ce) begin
      mode_reg <= mode_next;
      dout_reg <= dout_next;
      iimg_reg <= iimg_next;
    end
  end

endmodule
`default_nettype wire
